// ### hdl/pbs_regs.vh
// Constants of the pipelined burst memory port: widths, burst orders, timing.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef PBS_REGS_VH
`define PBS_REGS_VH
`define PBS_ADDR_W      17
`define PBS_LANES       4
`define PBS_LANE_W      9
`define PBS_DATA_W      36
`define PBS_ORDER_LIN   1'b0
`define PBS_ORDER_ILV   1'b1
`define PBS_FIFO_DEPTH  8
`define PBS_CLK_NS      100
`define PBS_WR_LAT      1
`endif

// ### hdl/pbs_fifo.v
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset, released synchronously by the parent.
module pbs_fifo #(
  parameter WIDTH = 53,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      if (push & ~pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 1'b1;
    end
  end

  // Storage needs no reset; only pointers define contents
  always @(posedge clk) begin
    if (push)
      mem[wr_q] <= in_data;
  end
endmodule // pbs_fifo

// ### hdl/pbs_port.v
// Synchronous port logic of a 128K x 36 pipelined burst memory with its own array.
// Assumes a bus master on ref_clk; the bench keeps data_in and data_out as separate pins and checks data_oe on its own.
`include "pbs_regs.vh"
module pbs_port #(
  parameter ADDR_W = `PBS_ADDR_W,
  parameter DEPTH  = `PBS_FIFO_DEPTH
) (
  input  wire                   ref_clk,
  input  wire                   rst_n,
  input  wire [ADDR_W-1:0]      addr,
  input  wire                   processor_addr_strobe_n,
  input  wire                   controller_addr_strobe_n,
  input  wire                   burst_advance_n,
  input  wire                   global_write_n,
  input  wire                   byte_write_enable_n,
  input  wire [`PBS_LANES-1:0]  byte_lane_write_n,
  input  wire                   chip_sel_first_n,
  input  wire                   chip_sel_second,
  input  wire                   chip_sel_third_n,
  input  wire                   output_enable_n,
  input  wire                   burst_order,
  input  wire                   sleep_request,
  input  wire [`PBS_DATA_W-1:0] data_in,
  output reg  [`PBS_DATA_W-1:0] data_out,
  output reg                    data_oe,
  output reg                    sleeping,
  output reg                    write_stall
);
  localparam WORDS  = 1 << ADDR_W;
  localparam ST_DES = 2'd0;
  localparam ST_RD  = 2'd1;
  localparam ST_WR  = 2'd2;
  localparam FW     = ADDR_W + `PBS_LANES + `PBS_DATA_W;

  //////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  reg        rst_m_q;
  reg        rst_s_q;
  reg  [1:0] oe_sync_q;
  reg  [1:0] zz_sync_q;
  reg        order_q;
  reg        order_taken_q;
  wire       rst_l;

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end
  assign rst_l = rst_s_q;

  // Asynchronous pins go through two flops; the first is read only by the second
  always @(posedge ref_clk or negedge rst_l) begin
    if (!rst_l) begin
      oe_sync_q <= 2'b11;
      zz_sync_q <= 2'b00;
    end else begin
      oe_sync_q <= {oe_sync_q[0], output_enable_n};
      zz_sync_q <= {zz_sync_q[0], sleep_request};
    end
  end

  // Strap is caught once after reset release and then held as static
  always @(posedge ref_clk or negedge rst_l) begin
    if (!rst_l) begin
      order_q       <= `PBS_ORDER_ILV;
      order_taken_q <= 1'b0;
    end else if (!order_taken_q) begin
      order_q       <= burst_order;
      order_taken_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Input registers: every synchronous pin captured on the rising edge
  reg [ADDR_W-1:0]      a_q;
  reg                   sp_q;
  reg                   sc_q;
  reg                   adv_q;
  reg                   gw_q;
  reg                   bwe_q;
  reg [`PBS_LANES-1:0]  bw_q;
  reg                   ce1_q;
  reg                   ce2_q;
  reg                   ce3_q;
  reg [`PBS_DATA_W-1:0] din_q;

  always @(posedge ref_clk or negedge rst_l) begin
    if (!rst_l) begin
      a_q   <= {ADDR_W{1'b0}};
      sp_q  <= 1'b1;
      sc_q  <= 1'b1;
      adv_q <= 1'b1;
      gw_q  <= 1'b1;
      bwe_q <= 1'b1;
      bw_q  <= {`PBS_LANES{1'b1}};
      ce1_q <= 1'b1;
      ce2_q <= 1'b0;
      ce3_q <= 1'b1;
      din_q <= {`PBS_DATA_W{1'b0}};
    end else begin
      a_q   <= addr;
      sp_q  <= processor_addr_strobe_n;
      sc_q  <= controller_addr_strobe_n;
      adv_q <= burst_advance_n;
      gw_q  <= global_write_n;
      bwe_q <= byte_write_enable_n;
      bw_q  <= byte_lane_write_n;
      ce1_q <= chip_sel_first_n;
      ce2_q <= chip_sel_second;
      ce3_q <= chip_sel_third_n;
      din_q <= data_in;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Strobe recognition and chip select decode
  function sel_ok;
    input c1n;
    input c2;
    input c3n;
    begin
      sel_ok = ~c1n & c2 & ~c3n;
    end
  endfunction

  wire sp_act  = ~sp_q & ~ce1_q;
  wire strobe  = sp_act | ~sc_q;
  // Select is looked at only on a load edge, never during continuation
  wire load    = strobe;
  wire sel_now = sel_ok(ce1_q, ce2_q, ce3_q);
  // Processor strobe starts a read; its write comes on a later continuation
  wire wr_req  = ~gw_q | (~bwe_q & ~(&bw_q));
  wire wr_cyc  = ~(sp_act) & wr_req;

  //////////////////////////////////////////////////////////////////////////////
  // Address register and burst counter
  reg [ADDR_W-1:0] base_q;
  reg [1:0]        ld_lo_q;
  reg [1:0]        beat_q;
  reg [1:0]        st_q;
  reg [1:0]        st_d;
  wire [1:0]       lo_addr;
  wire [ADDR_W-1:0] cur_addr;

  // An advancing edge already accesses the next beat, so the count is looked ahead
  wire [1:0]       beat_nx = (st_q != ST_DES && !adv_q) ? beat_q + 2'b01 : beat_q;

  // Linear adds the beat count, interleaved XORs it
  assign lo_addr  = (order_q == `PBS_ORDER_LIN) ? (ld_lo_q + beat_nx) : (ld_lo_q ^ beat_nx);
  assign cur_addr = {base_q[ADDR_W-1:2], lo_addr};

  always @* begin
    st_d = st_q;
    if (load) begin
      if (!sel_now)
        st_d = ST_DES;
      else if (wr_cyc)
        st_d = ST_WR;
      else
        st_d = ST_RD;
    end else if (st_q != ST_DES) begin
      st_d = wr_req ? ST_WR : ST_RD;
    end
  end

  always @(posedge ref_clk or negedge rst_l) begin
    if (!rst_l) begin
      base_q  <= {ADDR_W{1'b0}};
      ld_lo_q <= 2'b00;
      beat_q  <= 2'b00;
      st_q    <= ST_DES;
    end else if (!zz_sync_q[1]) begin
      st_q <= st_d;
      if (load && sel_now) begin
        base_q  <= a_q;
        ld_lo_q <= a_q[1:0];
        beat_q  <= 2'b00;
      end else begin
        beat_q  <= beat_nx;
      end
    end
  end

  // Address of the access in this cycle
  wire [ADDR_W-1:0] acc_addr = (load && sel_now) ? a_q : cur_addr;
  wire acc_sel = load ? sel_now : (st_q != ST_DES);
  wire acc_wr  = acc_sel & wr_req & ~(load & sp_act);
  wire acc_rd  = acc_sel & ~acc_wr;
  // Suspended beats keep the last word; only loads and advances read the array
  wire rd_go   = acc_rd & (load | ~adv_q);
  wire [`PBS_DATA_W-1:0] rd_word;

  //////////////////////////////////////////////////////////////////////////////
  // Write lanes queued through the FIFO to the array
  reg [`PBS_LANES-1:0] lanes;
  integer li;
  always @* begin
    lanes = {`PBS_LANES{1'b0}};
    for (li = 0; li < `PBS_LANES; li = li + 1) begin
      if (!gw_q)
        lanes[li] = 1'b1;
      else
        lanes[li] = ~bwe_q & ~bw_q[li];
    end
  end

  wire          f_in_ready;
  wire [FW-1:0] f_out;
  wire          f_out_valid;
  wire          do_wr = acc_wr & ~zz_sync_q[1];

  // Lanes, address and data come from the same edge's registers
  pbs_fifo #(
    .WIDTH (FW),
    .DEPTH (DEPTH),
    .AW    (3)
  ) u_fifo (
    .clk       (ref_clk),
    .rst_n     (rst_l),
    .in_data   ({acc_addr, lanes, din_q}),
    .in_valid  (do_wr),
    .in_ready  (f_in_ready),
    .out_data  (f_out),
    .out_valid (f_out_valid),
    .out_ready (~rd_go)
  );

  wire [ADDR_W-1:0]     w_addr  = f_out[FW-1 -: ADDR_W];
  wire [`PBS_LANES-1:0] w_lanes = f_out[`PBS_DATA_W +: `PBS_LANES];
  wire [`PBS_DATA_W-1:0] w_data = f_out[`PBS_DATA_W-1:0];

  // Drain pauses only on edges that read the array, so it has one access per cycle
  genvar g;
  generate
    for (g = 0; g < `PBS_LANES; g = g + 1) begin : g_lane
      reg [`PBS_LANE_W-1:0] lane_mem [0:WORDS-1];
      always @(posedge ref_clk) begin
        if (f_out_valid && !rd_go && w_lanes[g])
          lane_mem[w_addr] <= w_data[g*`PBS_LANE_W +: `PBS_LANE_W];
      end
      assign rd_word[g*`PBS_LANE_W +: `PBS_LANE_W] = lane_mem[acc_addr];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Pipelined read path and output enable mask
  reg rd_vld_q;

  always @(posedge ref_clk or negedge rst_l) begin
    if (!rst_l) begin
      data_out    <= {`PBS_DATA_W{1'b0}};
      data_oe     <= 1'b0;
      rd_vld_q    <= 1'b0;
      sleeping    <= 1'b0;
      write_stall <= 1'b0;
    end else begin
      sleeping    <= zz_sync_q[1];
      write_stall <= ~f_in_ready;
      rd_vld_q    <= acc_rd & ~zz_sync_q[1];
      if (rd_go && !zz_sync_q[1])
        data_out <= rd_word;
      // Reads stay coherent only after queued writes drain; a hazard to avoid
      data_oe <= ~oe_sync_q[0 + 1] & (acc_rd | rd_vld_q) & ~(acc_rd & (st_q == ST_DES));
    end
  end
endmodule // pbs_port

// ### verif/pbs_port_assertions.sv
// Pin-level timing checker for the burst memory port, bound to every pbs_port.
// Assumes ref_clk is the only clock and rst_n its active-low reset.
module pbs_port_assertions #(
  parameter ADDR_W = 17,
  parameter DEPTH  = 8
) (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        processor_addr_strobe_n,
  input wire logic        controller_addr_strobe_n,
  input wire logic        burst_advance_n,
  input wire logic        global_write_n,
  input wire logic        byte_write_enable_n,
  input wire logic        chip_sel_first_n,
  input wire logic        chip_sel_second,
  input wire logic        chip_sel_third_n,
  input wire logic        output_enable_n,
  input wire logic        sleep_request,
  input wire logic [35:0] data_out,
  input wire logic        data_oe,
  input wire logic        sleeping,
  input wire logic        write_stall
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire sel  = !chip_sel_first_n && chip_sel_second && !chip_sel_third_n;
  wire strb = !processor_addr_strobe_n || !controller_addr_strobe_n;
  wire rd_p = !processor_addr_strobe_n && sel && !sleep_request;
  // Processor strobe alone cannot deselect while the first select is high
  wire desel = (!controller_addr_strobe_n || !processor_addr_strobe_n && !chip_sel_first_n) && !sel;
  wire quiet = processor_addr_strobe_n && controller_addr_strobe_n && !output_enable_n && !sleep_request;
  wire wr = !global_write_n || !byte_write_enable_n;
  ////////////////////////////////////////////////////////////////
  rst_out_a: assert property ($rose(rst_n) |-> data_out == 36'h0_0000_0000 && !data_oe)
    else $error("outputs not clear after reset");
  oe_off_a: assert property (output_enable_n [*4] |=> !data_oe)
    else $error("data pins driven with output enable high");
  read_drive_a: assert property (rd_p ##1 quiet [*5] |-> data_oe)
    else $error("read data never driven");
  desel_float_a: assert property (desel ##1 rd_p |-> ##2 !data_oe)
    else $error("first read after deselect drove the pins");
  sleep_on_a: assert property (sleep_request [*5] |-> sleeping)
    else $error("sleep not entered");
  sleep_off_a: assert property (!sleep_request [*5] |-> !sleeping)
    else $error("sleep not left");
  dout_cause_a: assert property ($changed(data_out) |-> $past(strb, 2) || !$past(burst_advance_n, 2))
    else $error("read data changed without a strobe or advance");
  stall_cause_a: assert property ($rose(write_stall) |-> $past(wr, 1) || $past(wr, 2) || $past(wr, 3))
    else $error("write stall without a write");
endmodule // pbs_port_assertions
////////////////////////////////////////////////////////////////
bind pbs_port pbs_port_assertions #(.ADDR_W(ADDR_W), .DEPTH(DEPTH)) pbs_port_assertions_i (.*);

// ### verif/pbs_ctrl_model.sv
// Bus-master model: presents one beat of the port's synchronous inputs per cycle.
// Assumes a free-running ref_clk; each change lands 1 ns after a rising edge.
module pbs_ctrl_model (
  input  wire logic   ref_clk,
  output logic [16:0] addr,
  output logic        processor_addr_strobe_n,
  output logic        controller_addr_strobe_n,
  output logic        burst_advance_n,
  output logic        global_write_n,
  output logic        byte_write_enable_n,
  output logic [3:0]  byte_lane_write_n,
  output logic        chip_sel_first_n,
  output logic        chip_sel_second,
  output logic        chip_sel_third_n,
  output logic [35:0] data_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // s is {processor strobe, controller strobe, advance, global write, byte write enable}
  task automatic beat(input logic [4:0] s, input logic [3:0] ln, input logic [2:0] sel,
                      input logic [16:0] a, input logic [35:0] d);
    @(posedge ref_clk);
    #1;
    {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} = s[4:2];
    {global_write_n, byte_write_enable_n, byte_lane_write_n} = {s[1:0], ln};
    {chip_sel_first_n, chip_sel_second, chip_sel_third_n} = sel;
    addr    = a;
    data_in = d;
  endtask
  // Released bus flips address and data so a stale value never passes for a driven one
  task automatic rest;
    beat(5'h1F, 4'hF, 3'b010, ~addr, ~data_in);
  endtask
  initial begin
    {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} = 3'h7;
    {global_write_n, byte_write_enable_n, byte_lane_write_n} = 6'h3F;
    {chip_sel_first_n, chip_sel_second, chip_sel_third_n} = 3'h2;
    addr    = 17'h0_0000;
    data_in = 36'h0_0000_0000;
  end
endmodule // pbs_ctrl_model

// ### verif/pipelined_burst_sram_port_bench.sv
// Self-checking bench for the burst memory port: writes, bursts, selects, output enable, sleep.
// Assumes the bus model presents one beat per cycle and reads answer one edge after sampling.
module pipelined_burst_sram_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0, rst_n = 1'b0, output_enable_n = 1'b0, burst_order = 1'b0, sleep_request = 1'b0;
  wire [16:0] addr;
  wire [35:0] data_in, data_out;
  wire [3:0]  byte_lane_write_n;
  wire        processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n, global_write_n;
  wire        byte_write_enable_n, chip_sel_first_n, chip_sel_second, chip_sel_third_n;
  wire        data_oe, sleeping, write_stall;
  int errors = 0;
  int checks_done = 0;
  logic [35:0] mem [logic [16:0]];
  always #50 ref_clk = ~ref_clk;
  pbs_ctrl_model pbs_ctrl_model_i (.*);
  pbs_port #(.ADDR_W(17), .DEPTH(8)) pbs_port_i (.*);
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) pbs_ctrl_model_i.rest;
  endtask
  task automatic beat(input logic [4:0] s, input logic [2:0] sel, input logic [16:0] a);
    pbs_ctrl_model_i.beat(s, 4'hF, sel, a, ~data_in);
  endtask
  task automatic do_reset(input logic ilv);
    rst_n = 1'b0;
    burst_order = ilv;
    repeat (10) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    idle(3);
  endtask
  // ctl is {global write, byte write enable}; the idle beats let the write queue drain
  task automatic wr(input logic [16:0] a, input logic [1:0] ctl, input logic [3:0] ln, input logic [2:0] sel,
                    input logic [35:0] d);
    pbs_ctrl_model_i.beat({3'h5, ctl}, ln, sel, a, d);
    if (sel == 3'h2)
      for (int i = 0; i < 4; i++)
        if (!ctl[1] || !ctl[0] && !ln[i]) mem[a][i*9 +: 9] = d[i*9 +: 9];
    idle(3);
  endtask
  // Continuation beats deselect the chip on purpose: selects only count on load edges
  task automatic rd(input logic [16:0] a, input int n, input logic ilv);
    logic [16:0] e;
    for (int k = 0; k < n + 2; k++) begin
      if (k == 0) beat(5'h0F, 3'h2, a);
      else if (k < n) beat(5'h1B, 3'h5, ~a);
      else idle(1);
      if (k >= 2) begin
        e = {a[16:2], ilv ? a[1:0] ^ 2'(k - 2) : a[1:0] + 2'(k - 2)};
        check(data_out, mem[e]);
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_burst(input logic ilv, input logic [16:0] a);
    for (int i = 0; i < 4; i++)
      wr({a[16:2], 2'(i)}, 2'h1, 4'(i), 3'h2, 36'h1_2345_6780 + 36'(i));
    rd(a, 4, ilv);
  endtask
  task automatic t_lanes;
    logic [2:0] bad [3] = '{3'h6, 3'h0, 3'h3};
    wr(17'h0_0005, 2'h1, 4'hF, 3'h2, 36'hF_FFFF_FFFF);
    wr(17'h0_0005, 2'h2, 4'hA, 3'h2, 36'h0_0000_0000);
    wr(17'h0_0005, 2'h3, 4'h0, 3'h2, 36'h0_0000_0000);
    foreach (bad[i]) wr(17'h0_0005, 2'h1, 4'hF, bad[i], 36'h5_5555_5555);
    beat(5'h05, 3'h2, 17'h0_0005);
    idle(3);
    rd(17'h0_0005, 1, 1'b0);
  endtask
  task automatic t_oe;
    beat(5'h17, 3'h0, 17'h0_0000);
    beat(5'h0F, 3'h2, 17'h0_0005);
    beat(5'h0F, 3'h2, 17'h1_FFFC);
    idle(1);
    check({35'h0, data_oe}, 36'h0);
    check(data_out, mem[17'h0_0005]);
    idle(1);
    check(data_out, mem[17'h1_FFFC]);
    idle(1);
    check({35'h0, data_oe}, 36'h1);
    output_enable_n = 1'b1;
    idle(5);
    check({35'h0, data_oe}, 36'h0);
    output_enable_n = 1'b0;
  endtask
  // A write while asleep is dropped and stored data survives
  task automatic t_sleep;
    sleep_request = 1'b1;
    idle(6);
    check({35'h0, sleeping}, 36'h1);
    pbs_ctrl_model_i.beat(5'h15, 4'hF, 3'h2, 17'h0_0005, 36'h3_3333_3333);
    idle(3);
    sleep_request = 1'b0;
    idle(6);
    check({35'h0, sleeping}, 36'h0);
    rd(17'h0_0005, 1, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    do_reset(1'b0);
    t_burst(1'b0, 17'h1_FFFE);
    t_lanes;
    t_oe;
    t_sleep;
    do_reset(1'b1);
    t_burst(1'b1, 17'h1_FFFD);
    test_done;
  end
  // About 130 cycles of work; 3000 cycles, over twenty times that, means a hang
  initial begin
    #300_000;
    errors++;
    test_done;
  end
endmodule // pipelined_burst_sram_port_bench
